// ==== common/sfc_pkg.sv ====
// Package of constants for the semaphore flag port controller
package sfc_pkg;
  localparam int FLAG_COUNT = 8;
  localparam int INDEX_WIDTH = 3;
  localparam int ADDR_WIDTH = 17;
  localparam int DATA_WIDTH = 36;
  localparam int FREE_BIT_POS = 0;
  localparam logic FLAG_FREE = 1'b1;
  localparam logic FLAG_TAKE = 1'b0;
  // Strobe timing in ns; the device access time is taken as the floor
  localparam int SETUP_NS = 10;
  localparam int STROBE_NS = 15;
  localparam int GAP_NS = 10;
  localparam int CLK_NS = 4;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_WIDTH = 4;
  typedef enum logic [1:0]
  {
    SFC_OP_WRITE,
    SFC_OP_READ,
    SFC_OP_INIT
  } sfc_op_type;
endpackage : sfc_pkg

// ==== design/sfc_host.sv ====
// Host controller driving one port of the semaphore flag space
//
// Summary of operation
// RQ1: Eight flags are reached by index in their own select space.
// RQ2: Flag accesses never touch the array; the host never writes it here.
// RQ3: Only the low three address lines carry the index; upper lines held zero.
// RQ4: Write data bit zero: zero requests, one releases; flags active low.
// RQ5: Zero to a free flag gives ownership; read back zero confirms it.
// RQ6: Owner writing one frees the flag unless the other side is pending.
// RQ7: A zero from the non-owner is held pending until release.
// RQ8: On release a pending side takes ownership and reads zero.
// RQ9: A read returns the flag on all data bits, all ones or zeros.
// RQ10: Read value latched while select and output enable stay active.
// RQ11: Byte enables only gate outputs during reads.
// RQ12: Contending requests give the token to exactly one side.
// RQ13: Flags control no other resource in hardware.
// RQ14: One port never delays the other port.
// RQ15: Host writes zero first, then reads back to confirm ownership.
// RQ16: After a failed request host keeps polling or writes one to withdraw.
// RQ17: Host drops select and output enable between polling reads.
// RQ18: Host writes one to every flag after reset before other requests.
// RQ19: Host keeps array chip select high while flag select is low.
// RQ20: Same-step requests resolve by fixed port priority in a model.
`timescale 1ns/1ns
module sfc_host
  import sfc_pkg::*;
#(
  parameter int DW = DATA_WIDTH,
  parameter int AW = ADDR_WIDTH
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reqValid,
  input wire sfc_op_type reqOp,
  input wire logic [INDEX_WIDTH-1:0] reqIndex,
  input wire logic reqFree,
  output logic reqReady,
  output logic doneValid,
  output logic doneOwned,
  output logic initDone,
  output logic chipSelect_n,
  output logic flag_space_select_n,
  output logic writeEnable_n,
  output logic outputEnable_n,
  output logic byte_lane_enable_n,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] dataOut,
  output logic dataOutEn,
  input wire logic [DW-1:0] dataIn
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_GAP
  } sfc_state_type;

  logic [DW-1:0] dataSync;
  logic sampleBit;

  sfc_sync #(.WIDTH(DW)) u_sync
  (
    .clk(clk),
    .arst_n(arst_n),
    .din(dataIn),
    .dout(dataSync)
  );
  // Any bit carries the flag value; bit zero suffices
  assign sampleBit = dataSync[FREE_BIT_POS]; // see RQ9

  ////////////////////////////////////////////////////////////////////////
  sfc_state_type state, next_state;
  logic [CNT_WIDTH-1:0] cnt, next_cnt;
  sfc_op_type op, next_op;
  logic [INDEX_WIDTH-1:0] idx, next_idx;
  logic wbit, next_wbit;
  logic initRun, next_initRun;
  logic next_initDone, next_reqReady, next_doneValid, next_doneOwned;
  logic next_chipSelect_n, next_flag_space_select_n, next_writeEnable_n;
  logic next_outputEnable_n, next_byte_lane_enable_n, next_dataOutEn;
  logic [AW-1:0] next_addr;
  logic [DW-1:0] next_dataOut;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_op = op;
    next_idx = idx;
    next_wbit = wbit;
    next_initRun = initRun;
    next_initDone = initDone;
    next_reqReady = 1'b0;
    next_doneValid = 1'b0;
    next_doneOwned = doneOwned;
    next_chipSelect_n = 1'b1; // see RQ19
    next_flag_space_select_n = 1'b1;
    next_writeEnable_n = 1'b1;
    next_outputEnable_n = 1'b1;
    next_byte_lane_enable_n = 1'b1;
    next_dataOutEn = 1'b0;
    next_addr = addr;
    next_dataOut = dataOut;
    case (state)
      ST_IDLE:
      begin
        if (initRun)
        begin
          // Device has no reset of its own, so every flag is freed first
          next_op = SFC_OP_INIT; // see RQ18
          next_wbit = FLAG_FREE;
          next_state = ST_SETUP;
          next_cnt = '0;
        end
        else if (reqValid && reqReady)
        begin
          next_op = reqOp;
          next_idx = reqIndex;
          // Request is zero, release or withdraw is one
          next_wbit = (reqOp == SFC_OP_WRITE) ? reqFree : FLAG_FREE; // see RQ4 RQ16
          next_state = ST_SETUP;
          next_cnt = '0;
        end
        else
        begin
          next_reqReady = 1'b1;
        end
      end
      ST_SETUP:
      begin
        next_flag_space_select_n = 1'b0;
        // Upper address lines unused by the flag space
        next_addr = {{(AW-INDEX_WIDTH){1'b0}}, idx}; // see RQ1 RQ3
        next_dataOut = {{(DW-1){1'b0}}, wbit};
        next_byte_lane_enable_n = 1'b0;
        next_dataOutEn = (op != SFC_OP_READ);
        next_outputEnable_n = (op != SFC_OP_READ);
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_WIDTH'(SETUP_CYC - 1))
        begin
          next_state = ST_STROBE;
          next_cnt = '0;
        end
      end
      ST_STROBE:
      begin
        next_flag_space_select_n = 1'b0;
        next_byte_lane_enable_n = 1'b0;
        next_dataOutEn = (op != SFC_OP_READ);
        next_outputEnable_n = (op != SFC_OP_READ);
        next_writeEnable_n = (op == SFC_OP_READ);
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_WIDTH'(STROBE_CYC + 1))
        begin
          // Margin of two cycles covers the synchroniser
          next_state = ST_GAP;
          next_cnt = '0;
          next_writeEnable_n = 1'b1;
          if (op == SFC_OP_READ)
          begin
            next_doneOwned = (sampleBit == FLAG_TAKE); // see RQ15 RQ5 RQ8
          end
        end
      end
      ST_GAP:
      begin
        // Select and output enable both dropped so the next poll relatches
        next_cnt = cnt + 1'b1; // see RQ17
        if (cnt == CNT_WIDTH'(GAP_CYC - 1))
        begin
          next_state = ST_IDLE;
          next_cnt = '0;
          // Only the power-up sweep steps the index; a user INIT is one plain write
          if (initRun)
          begin
            next_idx = idx + 1'b1;
            if (idx == INDEX_WIDTH'(FLAG_COUNT - 1))
            begin
              next_initRun = 1'b0;
              next_initDone = 1'b1;
              next_reqReady = 1'b1;
            end
          end
          else
          begin
            next_doneValid = 1'b1;
            next_reqReady = 1'b1;
          end
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      op <= SFC_OP_INIT;
      idx <= '0;
      wbit <= FLAG_FREE;
      initRun <= 1'b1;
      initDone <= 1'b0;
      reqReady <= 1'b0;
      doneValid <= 1'b0;
      doneOwned <= 1'b0;
      chipSelect_n <= 1'b1;
      flag_space_select_n <= 1'b1;
      writeEnable_n <= 1'b1;
      outputEnable_n <= 1'b1;
      byte_lane_enable_n <= 1'b1;
      dataOutEn <= 1'b0;
      addr <= '0;
      dataOut <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      op <= next_op;
      idx <= next_idx;
      wbit <= next_wbit;
      initRun <= next_initRun;
      initDone <= next_initDone;
      reqReady <= next_reqReady;
      doneValid <= next_doneValid;
      doneOwned <= next_doneOwned;
      chipSelect_n <= next_chipSelect_n;
      flag_space_select_n <= next_flag_space_select_n;
      writeEnable_n <= next_writeEnable_n;
      outputEnable_n <= next_outputEnable_n;
      byte_lane_enable_n <= next_byte_lane_enable_n;
      dataOutEn <= next_dataOutEn;
      addr <= next_addr;
      dataOut <= next_dataOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  array_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    chipSelect_n) else $error("array select driven"); // see RQ19
  upper_addr_a: assert property (@(posedge clk) disable iff (!arst_n)
    !flag_space_select_n |-> addr[AW-1:INDEX_WIDTH] == '0)
    else $error("upper address not zero"); // see RQ3
  write_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
    !writeEnable_n |-> dataOutEn && dataOut[DW-1:1] == '0)
    else $error("write data malformed"); // see RQ4
  poll_gap_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(flag_space_select_n) |-> flag_space_select_n [*2])
    else $error("select gap too short"); // see RQ17
  init_first_a: assert property (@(posedge clk) disable iff (!arst_n)
    !initDone && !writeEnable_n |-> dataOut[0] == FLAG_FREE)
    else $error("init wrote a request"); // see RQ18
  read_no_we_a: assert property (@(posedge clk) disable iff (!arst_n)
    !outputEnable_n |-> writeEnable_n && !dataOutEn)
    else $error("read overlaps write"); // see RQ15
  done_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    doneValid |=> !doneValid) else $error("done not a pulse"); // see RQ16
  init_end_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(initDone) |-> reqReady) else $error("ready missing"); // see RQ18
  read_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
    doneValid && op == SFC_OP_READ && doneOwned);
  fail_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
    doneValid && op == SFC_OP_READ && !doneOwned);
  init_cov_c: cover property (@(posedge clk) disable iff (!arst_n) $rose(initDone));
endmodule : sfc_host

// ==== design/sfc_sync.sv ====
// Two-stage synchroniser for pin inputs, one instance covers the whole WIDTH-bit bus
`timescale 1ns/1ns
module sfc_sync
  import sfc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  always_comb
  begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= '0;
      dout <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule : sfc_sync

// ==== testbench/sfc_flag_model.sv ====
// Behavioural two-port semaphore flag device facing the host
`timescale 1ns/1ns
module sfc_flag_model
  import sfc_pkg::*;
(
  input wire logic chipSelect_n,
  input wire logic flag_space_select_n,
  input wire logic writeEnable_n,
  input wire logic outputEnable_n,
  input wire logic byte_lane_enable_n,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic [DATA_WIDTH-1:0] dataOut,
  input wire logic dataOutEn,
  output logic [DATA_WIDTH-1:0] dataIn,
  input wire logic pSel_n,
  input wire logic pWe_n,
  input wire logic pOe_n,
  input wire logic [INDEX_WIDTH-1:0] pIdx,
  input wire logic pBit,
  output logic pRd
);
  // Owner 0 free, 1 host side, 2 peer side
  logic [1:0] owner [FLAG_COUNT];
  logic [1:0] req [FLAG_COUNT];
  logic hLat = 1'b1;
  wire hRd = !flag_space_select_n && !outputEnable_n && !byte_lane_enable_n;
  // No power-up clearing: owners start dirty, requests start pending (zero) on both sides
  initial
    for (int i = 0; i < FLAG_COUNT; i++)
    begin
      owner[i] = 2'h1 + 2'(i % 2);
      req[i] = 2'h0;
    end
  ////////////////////////////////////////
  task automatic flagWr(input int s, input logic [INDEX_WIDTH-1:0] i, input logic d);
    req[i][s] = d;
    if (d == FLAG_TAKE && owner[i] == 2'h0)
      owner[i] = 2'(s + 1);
    else if (d == FLAG_FREE && owner[i] == 2'(s + 1))
      owner[i] = req[i][1-s] ? 2'h0 : 2'(2 - s);
  endtask : flagWr
  always @(negedge writeEnable_n)
    if (!flag_space_select_n && chipSelect_n && dataOutEn)
      flagWr(0, addr[INDEX_WIDTH-1:0], dataOut[FREE_BIT_POS]);
  // Peer lands one step later, so a tie always goes to the host port
  always @(negedge pWe_n)
    if (!pSel_n)
      #1 flagWr(1, pIdx, pBit);
  // Latched a step late so the index has settled
  always @(posedge hRd)
    #1 hLat = owner[addr[INDEX_WIDTH-1:0]] != 2'h1;
  // Released bus shows the inverse so a stale read cannot pass
  assign dataIn = {DATA_WIDTH{hRd ~^ hLat}};
  always @(negedge pOe_n)
    pRd = owner[pIdx] != 2'h2;
endmodule : sfc_flag_model

// ==== testbench/tb_sfc_host.sv ====
// Self-checking bench for the semaphore flag host controller
`timescale 1ns/1ns
module tb_sfc_host
  import sfc_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n, reqValid, reqFree, reqReady, doneValid, doneOwned, initDone;
  logic chipSelect_n, flag_space_select_n, writeEnable_n, outputEnable_n;
  logic byte_lane_enable_n, dataOutEn, pSel_n, pWe_n, pOe_n, pBit, pRd, h, p;
  sfc_op_type reqOp;
  logic [INDEX_WIDTH-1:0] reqIndex, pIdx;
  logic [ADDR_WIDTH-1:0] addr;
  logic [DATA_WIDTH-1:0] dataOut, dataIn;
  int mismatches = 0;
  int checked = 0;
  always #(CLK_NS / 2) clk = ~clk;
  sfc_host dut_u (.clk, .arst_n, .reqValid, .reqOp, .reqIndex, .reqFree, .reqReady,
    .doneValid, .doneOwned, .initDone, .chipSelect_n, .flag_space_select_n,
    .writeEnable_n, .outputEnable_n, .byte_lane_enable_n, .addr, .dataOut,
    .dataOutEn, .dataIn);
  sfc_flag_model dev_u (.chipSelect_n, .flag_space_select_n, .writeEnable_n,
    .outputEnable_n, .byte_lane_enable_n, .addr, .dataOut, .dataOutEn, .dataIn,
    .pSel_n, .pWe_n, .pOe_n, .pIdx, .pBit, .pRd);
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic hostOp(input sfc_op_type op, input int idx, input logic fr);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 99)
    begin
      @(negedge clk);
      n++;
    end
    reqValid = 1'b1;
    reqOp = op;
    reqIndex = 3'(idx);
    reqFree = fr;
    @(negedge clk);
    reqValid = 1'b0;
    n = 0;
    while (doneValid !== 1'b1 && n < 99)
    begin
      @(negedge clk);
      n++;
    end
    // Strobe phase carries two extra cycles for the data synchroniser
    chk("latency", SETUP_CYC + STROBE_CYC + 2 + GAP_CYC, n);
    chk("reqReady", 1, reqReady);
    h = doneOwned;
  endtask : hostOp
  // Peer does one write or one read per call and drops select between accesses
  task automatic peerOp(input logic wr, input int idx, input logic b);
    pIdx = 3'(idx);
    pBit = b;
    pSel_n = 1'b0;
    @(negedge clk);
    pWe_n = !wr;
    pOe_n = wr;
    @(negedge clk);
    p = pRd;
    pWe_n = 1'b1;
    pOe_n = 1'b1;
    @(negedge clk);
    pSel_n = 1'b1;
    @(negedge clk);
  endtask : peerOp
  task automatic t_init();
    int n;
    n = 0;
    while (initDone !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk("initDone", 1, initDone);
    chk("chipSelect_n", 1, chipSelect_n);
    for (int i = 0; i < FLAG_COUNT; i++)
      peerOp(1, i, FLAG_FREE);
    for (int i = 0; i < FLAG_COUNT; i++)
    begin
      hostOp(SFC_OP_READ, i, 1'b0);
      chk("free", 0, h);
    end
    $display("test init done");
  endtask : t_init
  task automatic t_claim();
    for (int i = 0; i < FLAG_COUNT; i++)
    begin
      hostOp(SFC_OP_WRITE, i, FLAG_TAKE);
      hostOp(SFC_OP_READ, i, 1'b0);
      chk("host owns", 1, h);
      peerOp(0, i, 1'b0);
      chk("peer sees", 1, p);
      hostOp(SFC_OP_WRITE, i, FLAG_FREE);
      peerOp(1, i, FLAG_TAKE);
      peerOp(0, i, 1'b0);
      chk("peer owns", 0, p);
      peerOp(1, i, FLAG_FREE);
    end
    $display("test claim done");
  endtask : t_claim
  task automatic t_pend();
    hostOp(SFC_OP_WRITE, 2, FLAG_TAKE);
    peerOp(1, 2, FLAG_TAKE);
    peerOp(0, 2, 1'b0);
    chk("peer locked", 1, p);
    hostOp(SFC_OP_INIT, 2, FLAG_TAKE);
    peerOp(0, 2, 1'b0);
    chk("peer handed", 0, p);
    hostOp(SFC_OP_WRITE, 2, FLAG_TAKE);
    hostOp(SFC_OP_READ, 2, 1'b0);
    chk("host pending", 0, h);
    peerOp(1, 2, FLAG_FREE);
    hostOp(SFC_OP_READ, 2, 1'b0);
    chk("host handed", 1, h);
    hostOp(SFC_OP_WRITE, 2, FLAG_FREE);
    $display("test pend done");
  endtask : t_pend
  task automatic t_race();
    fork
      hostOp(SFC_OP_WRITE, 5, FLAG_TAKE);
      begin
        repeat (4) @(negedge clk);
        peerOp(1, 5, FLAG_TAKE);
      end
    join
    hostOp(SFC_OP_READ, 5, 1'b0);
    peerOp(0, 5, 1'b0);
    chk("one owner", 1, h ^ !p);
    hostOp(SFC_OP_WRITE, 5, FLAG_FREE);
    peerOp(1, 5, FLAG_FREE);
    peerOp(0, 5, 1'b0);
    chk("race free", 1, p);
    $display("test race done");
  endtask : t_race
  initial
  begin
    arst_n = 1'b0;
    reqValid = 1'b0;
    reqOp = SFC_OP_READ;
    reqIndex = 3'h0;
    reqFree = 1'b1;
    pSel_n = 1'b1;
    pWe_n = 1'b1;
    pOe_n = 1'b1;
    pIdx = 3'h0;
    pBit = 1'b1;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    t_init();
    t_claim();
    t_pend();
    t_race();
    close_out();
  end
  // Run needs about 3.3 us; the margin covers a slow handshake
  initial
  begin
    #40000;
    mismatches++;
    $display("watchdog expired");
    close_out();
  end
endmodule : tb_sfc_host
